/* File: hdl/pfs_supervisor.sv */
// Operation
// - any logic or gate-drive supply low: all outputs hi-z, alarm low at once
// - supply undervoltage clears itself once every supply is back up
// - power-on reset clears the overload latches before running
// - reset input low releases the alarm line high, whatever the faults
// - alarm and warning lines are active-low open-drain outputs
// - every fault that shuts the device down, except stuck pwm, pulls the alarm low
// - warning line low while junction is above 125 c
// - alarm and warning pair encode shutdown, overload, warning or normal
// - global fault other than thermal warning stops switching on all channels; all but warning and stuck pwm on all channels pull alarm low
// - latched faults hold until the controller toggles reset low then high
// - channel fault stops only the affected channels
// - output, logic, gate-drive, analog undervoltage: global, reported, self-clearing
// - bootstrap undervoltage turns off only that high side, unreported
// - thermal warning: global, warning line only, outputs keep running
// - latching overcurrent mode: reported channel shutdown until reset toggle
// - limiting mode: flip state at fs/2, unreported, clears by itself unless it lasts CBC_LIMIT_CYC cycles, then a latched, reported channel shutdown
// - stuck pwm on some channels is a channel fault, on all a global one
// - pwm below the least frame rate counts as stuck
// - reset input low forces all four half-bridges into hi-z
`timescale 1ns/100ps
module pfs_supervisor
    import pfs_pkg::*;
#(
    parameter int CBC_LIMIT_CYC = CBC_ESCALATE_CYC
) (
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic ctrl_reset_n,
    input wire logic [NUM_CH-1:0] supply_uv,
    input wire logic digital_core_rail_uv,
    input wire logic temp_warn_above,
    input wire logic temp_warn_below_low,
    input wire logic thermal_shutdown,
    input wire logic oc_latch_strap,
    input wire logic [NUM_CH-1:0] overcurrent,
    input wire logic [NUM_CH-1:0] bootstrap_cap_uv,
    input wire logic [NUM_CH-1:0] pwm_in,
    output logic [NUM_CH-1:0] bridge_hiz,
    output logic [NUM_CH-1:0] high_side_off,
    output logic [NUM_CH-1:0] cbc_flip,
    output logic shutdown_alarm_n_o,
    output logic shutdown_alarm_n_oe,
    output logic thermal_warning_n_o,
    output logic thermal_warning_n_oe
);

    // ****************************************
    // declarations
    // ****************************************
    pfs_state_t state_r, state_nxt;
    logic strap_taken_r, strap_taken_nxt;
    logic latch_mode_r, latch_mode_nxt;
    logic warn_r, warn_nxt;
    logic [NUM_CH-1:0] hiz_r, hiz_nxt;
    logic [NUM_CH-1:0] hs_off_r, hs_off_nxt;
    logic [NUM_CH-1:0] flip_r, flip_nxt;
    logic alarm_oe_r, alarm_oe_nxt;
    logic warn_oe_r, warn_oe_nxt;
    logic pin_low_r;
    pfs_chan_stat_t [NUM_CH-1:0] chan;
    logic [NUM_CH-1:0] stuck_v, ovl_v;
    logic undervoltage_trip, self_fault, global_off, chan_clear;

    // ****************************************
    // per-channel monitors
    // ****************************************
    // power-on reset or reset low clears latches
    assign chan_clear = !ctrl_reset_n || digital_core_rail_uv;

    for (genvar i = 0; i < NUM_CH; i++) begin : g_ch
        pfs_chan #(
            .STUCK_CYC(PWM_STUCK_CYC),
            .ESC_CYC(CBC_LIMIT_CYC)
        ) u_chan (
            .ref_clk(ref_clk),
            .rst(rst),
            .pwm_in(pwm_in[i]),
            .overcurrent(overcurrent[i]),
            .latch_mode(latch_mode_r),
            .clear(chan_clear),
            .stat(chan[i])
        );
        assign stuck_v[i] = chan[i].stuck;
        assign ovl_v[i] = chan[i].overload_trip;
    end

    // ****************************************
    // global state
    // ****************************************
    always_comb begin
        undervoltage_trip = |supply_uv;
        // core rail acts as power-on reset
        self_fault = undervoltage_trip || digital_core_rail_uv || (&stuck_v);
        // strap read once after reset release; the resistor never changes in use
        strap_taken_nxt = 1'b1;
        latch_mode_nxt = strap_taken_r ? latch_mode_r : oc_latch_strap;
        state_nxt = state_r;
        unique case (state_r)
            PFS_ST_RESET: begin
                if (ctrl_reset_n) begin
                    state_nxt = PFS_ST_RUN;
                end
            end
            PFS_ST_RUN, PFS_ST_SELF: begin
                if (!ctrl_reset_n) begin
                    state_nxt = PFS_ST_RESET;
                end else if (thermal_shutdown) begin
                    state_nxt = PFS_ST_TRIP;
                end else if (self_fault) begin
                    state_nxt = PFS_ST_SELF;
                end else begin
                    state_nxt = PFS_ST_RUN;
                end
            end
            PFS_ST_TRIP: begin
                // only a reset toggle leaves the trip
                if (!ctrl_reset_n) begin
                    state_nxt = PFS_ST_RESET;
                end
            end
        endcase
    end

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            state_r <= PFS_ST_RESET;
            strap_taken_r <= 1'b0;
            latch_mode_r <= OC_LATCH_RST;
        end else begin
            state_r <= state_nxt;
            strap_taken_r <= strap_taken_nxt;
            latch_mode_r <= latch_mode_nxt;
        end
    end

    // ****************************************
    // outputs
    // ****************************************
    always_comb begin
        global_off = !ctrl_reset_n || self_fault || thermal_shutdown
            || (state_r == PFS_ST_TRIP);
        // channel faults stop their own bridge only
        hiz_nxt = {NUM_CH{global_off}} | stuck_v | ovl_v;
        hs_off_nxt = bootstrap_cap_uv & ~hiz_nxt;
        for (int i = 0; i < NUM_CH; i++) begin
            flip_nxt[i] = chan[i].flip;
        end
        // warning with hysteresis, no effect on outputs
        if (temp_warn_above) begin
            warn_nxt = 1'b1;
        end else if (temp_warn_below_low) begin
            warn_nxt = 1'b0;
        end else begin
            warn_nxt = warn_r;
        end
        // reported shutdowns pull the alarm; reset releases it
        alarm_oe_nxt = ctrl_reset_n && (undervoltage_trip || digital_core_rail_uv
            || thermal_shutdown || (state_r == PFS_ST_TRIP) || (|ovl_v));
        warn_oe_nxt = warn_nxt;
    end

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            hiz_r <= HIZ_RST;
            hs_off_r <= '0;
            flip_r <= '0;
            warn_r <= 1'b0;
            alarm_oe_r <= 1'b0;
            warn_oe_r <= 1'b0;
            pin_low_r <= 1'b0;
        end else begin
            hiz_r <= hiz_nxt;
            hs_off_r <= hs_off_nxt;
            flip_r <= flip_nxt;
            warn_r <= warn_nxt;
            alarm_oe_r <= alarm_oe_nxt;
            warn_oe_r <= warn_oe_nxt;
            pin_low_r <= 1'b0;
        end
    end

    assign shutdown_alarm_n_o = pin_low_r;
    assign thermal_warning_n_o = pin_low_r;
    assign shutdown_alarm_n_oe = alarm_oe_r;
    assign thermal_warning_n_oe = warn_oe_r;
    assign bridge_hiz = hiz_r;
    assign high_side_off = hs_off_r;
    assign cbc_flip = flip_r;

    // ****************************************
    // assertions
    // ****************************************
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (rst);

    property p_uv_hiz;
        (ctrl_reset_n && |supply_uv) |=> (&bridge_hiz && shutdown_alarm_n_oe);
    endproperty
    a_uv_hiz: assert property (p_uv_hiz) else $error("uv did not shut down");

    property p_uv_resume;
        (state_r == PFS_ST_SELF && ctrl_reset_n && !self_fault && !thermal_shutdown)
            |=> state_r == PFS_ST_RUN;
    endproperty
    a_uv_resume: assert property (p_uv_resume) else $error("no self recovery");

    property p_por_clear;
        (digital_core_rail_uv && overcurrent == '0)
            ##1 (digital_core_rail_uv && overcurrent == '0) |=> ovl_v == '0;
    endproperty
    a_por_clear: assert property (p_por_clear) else $error("por left a latch");

    property p_reset_release;
        !ctrl_reset_n |=> (!shutdown_alarm_n_oe && &bridge_hiz);
    endproperty
    a_reset_release: assert property (p_reset_release) else $error("reset low not obeyed");

    property p_open_drain;
        !shutdown_alarm_n_o && !thermal_warning_n_o;
    endproperty
    a_open_drain: assert property (p_open_drain) else $error("pin driven high");

    property p_trip_hold;
        (state_r == PFS_ST_TRIP && ctrl_reset_n) |=> (state_r == PFS_ST_TRIP
            && shutdown_alarm_n_oe && &bridge_hiz);
    endproperty
    a_trip_hold: assert property (p_trip_hold) else $error("trip released early");

    property p_warn;
        temp_warn_above |=> thermal_warning_n_oe
            ##1 (thermal_warning_n_oe || $past(temp_warn_below_low));
    endproperty
    a_warn: assert property (p_warn) else $error("warning not shown");

    property p_chan_only;
        (!global_off && ovl_v[0] && !stuck_v[1] && !ovl_v[1]) |=> (bridge_hiz[0] && !bridge_hiz[1]);
    endproperty
    a_chan_only: assert property (p_chan_only) else $error("channel fault spread");

    property p_latched_oc;
        (latch_mode_r && overcurrent[0] && !global_off) |=> ##1 (bridge_hiz[0]
            && (shutdown_alarm_n_oe || !$past(ctrl_reset_n)));
    endproperty
    a_latched_oc: assert property (p_latched_oc) else $error("overcurrent not latched");

    property p_bst;
        (bootstrap_cap_uv[2] && !hiz_nxt[2]) |=> (high_side_off[2] && !bridge_hiz[2]);
    endproperty
    a_bst: assert property (p_bst) else $error("bootstrap handling wrong");

    property p_all_stuck;
        (&stuck_v && ctrl_reset_n && !undervoltage_trip && !digital_core_rail_uv
            && !thermal_shutdown && state_r != PFS_ST_TRIP && ovl_v == '0)
            |=> (&bridge_hiz && !shutdown_alarm_n_oe);
    endproperty
    a_all_stuck: assert property (p_all_stuck) else $error("stuck handling wrong");

    property p_core_por;
        (ctrl_reset_n && digital_core_rail_uv) |=> (&bridge_hiz && shutdown_alarm_n_oe);
    endproperty
    a_core_por: assert property (p_core_por) else $error("core rail low not obeyed");

    property p_ovl_alarm;
        (ctrl_reset_n && |ovl_v) |=> shutdown_alarm_n_oe;
    endproperty
    a_ovl_alarm: assert property (p_ovl_alarm) else $error("overload not reported");

    property p_trip_alarm;
        (ctrl_reset_n && thermal_shutdown) |=> (&bridge_hiz && shutdown_alarm_n_oe);
    endproperty
    a_trip_alarm: assert property (p_trip_alarm) else $error("shutdown not global");

    property p_normal;
        (ctrl_reset_n && !self_fault && !thermal_shutdown && state_r != PFS_ST_TRIP
            && ovl_v == '0 && stuck_v == '0) |=> (bridge_hiz == '0 && !shutdown_alarm_n_oe);
    endproperty
    a_normal: assert property (p_normal) else $error("outputs stopped without fault");

    property p_limit_quiet;
        (chan[0].cycle_current_limit && !global_off && ovl_v == '0 && !stuck_v[0])
            |=> (!bridge_hiz[0] && !shutdown_alarm_n_oe);
    endproperty
    a_limit_quiet: assert property (p_limit_quiet) else $error("limiting reported");

    property p_reset_hiz;
        !ctrl_reset_n |=> (&bridge_hiz && high_side_off == '0);
    endproperty
    a_reset_hiz: assert property (p_reset_hiz) else $error("bridge live in reset");

    property p_pwm_live;
        $changed(pwm_in[1]) |=> !stuck_v[1];
    endproperty
    a_pwm_live: assert property (p_pwm_live) else $error("live pwm seen as stuck");

    c_trip: cover property (state_r == PFS_ST_TRIP ##1 state_r == PFS_ST_RESET);
    c_self: cover property (state_r == PFS_ST_SELF ##1 state_r == PFS_ST_RUN);
    c_flip: cover property (cbc_flip[0] ##1 !cbc_flip[0]);
    c_warn: cover property (thermal_warning_n_oe && !shutdown_alarm_n_oe);

endmodule // pfs_supervisor

/* File: hdl/pfs_pkg.sv */
package pfs_pkg;

    // ****************************************
    // clock and timing
    // ****************************************
    localparam int CLK_PERIOD_NS = 40;
    // escalation of continuous current limiting, in microseconds
    localparam int CBC_ESCALATE_US = 2600;
    // a least time, so it rounds up
    localparam int CBC_ESCALATE_CYC = (CBC_ESCALATE_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    // longest quiet time of a live pwm input, in nanoseconds
    localparam int PWM_STUCK_NS = 10000;
    localparam int PWM_STUCK_CYC = (PWM_STUCK_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    // warning level reported on the warning line, in degrees c
    localparam int WARN_TEMP_C = 125;

    // ****************************************
    // widths and indices
    // ****************************************
    localparam int NUM_CH = 4;
    localparam int CNT_W = 17;
    localparam int SUP_OUTPUT_STAGE = 0;
    localparam int SUP_GATE_DRIVE = 1;
    localparam int SUP_LOGIC = 2;
    localparam int SUP_ANALOG = 3;

    // ****************************************
    // reset values
    // ****************************************
    localparam logic [NUM_CH-1:0] HIZ_RST = 4'hf;
    localparam logic [CNT_W-1:0] CNT_RST = 17'h0;
    localparam logic OC_LATCH_RST = 1'b1;

    // ****************************************
    // types
    // ****************************************
    typedef enum logic [1:0] {
        PFS_ST_RESET = 2'h0,
        PFS_ST_RUN = 2'h1,
        PFS_ST_SELF = 2'h3,
        PFS_ST_TRIP = 2'h2
    } pfs_state_t;

    typedef struct packed {
        logic stuck;
        logic overload_trip;
        logic cycle_current_limit;
        logic flip;
    } pfs_chan_stat_t;

endpackage

/* File: hdl/pfs_chan.sv */
`timescale 1ns/100ps
module pfs_chan
    import pfs_pkg::*;
#(
    parameter int STUCK_CYC = PWM_STUCK_CYC,
    parameter int ESC_CYC = CBC_ESCALATE_CYC
) (
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic pwm_in,
    input wire logic overcurrent,
    input wire logic latch_mode,
    input wire logic clear,
    output pfs_chan_stat_t stat
);

    logic pwm_d_r, pwm_d_nxt;
    logic [CNT_W-1:0] quiet_cnt_r, quiet_cnt_nxt;
    logic [CNT_W-1:0] cbc_cnt_r, cbc_cnt_nxt;
    logic flip_r, flip_nxt;
    logic ovl_r, ovl_nxt;
    logic stuck, limiting, ovl_set;

    always_comb begin
        pwm_d_nxt = pwm_in;
        stuck = (quiet_cnt_r == CNT_W'(STUCK_CYC));
        // no edge for too long means the frame rate fell too low
        if (pwm_in != pwm_d_r) begin
            quiet_cnt_nxt = CNT_RST;
        end else if (stuck) begin
            quiet_cnt_nxt = quiet_cnt_r;
        end else begin
            quiet_cnt_nxt = quiet_cnt_r + 17'h1;
        end
        limiting = !latch_mode && overcurrent;
        if (limiting) begin
            flip_nxt = (pwm_in && !pwm_d_r) ? !flip_r : flip_r;
        end else begin
            flip_nxt = 1'b0;
        end
        if (!limiting) begin
            cbc_cnt_nxt = CNT_RST;
        end else if (cbc_cnt_r == CNT_W'(ESC_CYC)) begin
            cbc_cnt_nxt = cbc_cnt_r;
        end else begin
            cbc_cnt_nxt = cbc_cnt_r + 17'h1;
        end
        ovl_set = (latch_mode && overcurrent) || (cbc_cnt_r == CNT_W'(ESC_CYC));
        // a new trip beats a clear in the same cycle
        ovl_nxt = ovl_set || (ovl_r && !clear);
        stat = '{stuck: stuck, overload_trip: ovl_r, cycle_current_limit: limiting, flip: flip_r};
    end

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            pwm_d_r <= 1'b0;
            quiet_cnt_r <= CNT_RST;
            cbc_cnt_r <= CNT_RST;
            flip_r <= 1'b0;
            ovl_r <= 1'b0;
        end else begin
            pwm_d_r <= pwm_d_nxt;
            quiet_cnt_r <= quiet_cnt_nxt;
            cbc_cnt_r <= cbc_cnt_nxt;
            flip_r <= flip_nxt;
            ovl_r <= ovl_nxt;
        end
    end

endmodule // pfs_chan

/* File: sim/pfs_ctrl_model.sv */
`timescale 1ns/100ps
module pfs_ctrl_model #(
    parameter int GAP_CYC = 100000
) (
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic alarm_n_o,
    input wire logic alarm_n_oe,
    input wire logic warn_n_o,
    input wire logic warn_n_oe,
    input wire logic clear_req,
    output logic ctrl_reset_n,
    output logic alarm_line,
    output logic warn_line,
    output logic busy
);
    // ****************************************
    // status lines with board pull-ups
    // ****************************************
    int gap_r;
    logic alarm_prev_r;
    assign alarm_line = alarm_n_oe ? alarm_n_o : 1'b1;
    assign warn_line = warn_n_oe ? warn_n_o : 1'b1;
    assign busy = ~ctrl_reset_n;

    // ****************************************
    // reset toggling
    // ****************************************
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            gap_r <= GAP_CYC;
            alarm_prev_r <= 1'b1;
            ctrl_reset_n <= 1'b1;
        end else begin
            alarm_prev_r <= alarm_line;
            if (alarm_prev_r && !alarm_line) begin
                gap_r <= 0;
            end else if (gap_r < GAP_CYC) begin
                gap_r <= gap_r + 1;
            end
            if (clear_req) begin
                ctrl_reset_n <= 1'b0;
            end else if (!ctrl_reset_n && gap_r >= GAP_CYC && warn_line) begin
                ctrl_reset_n <= 1'b1;
            end
        end
    end
endmodule // pfs_ctrl_model

/* File: sim/tb_pfs_supervisor.sv */
`timescale 1ns/100ps
module tb_pfs_supervisor;
    import pfs_pkg::*;
    // short escalation count keeps the run brief
    localparam int LIM = 20;
    logic ref_clk, rst, ctrl_reset_n, core_uv, above, below, tsd, strap, clear_req;
    logic alarm_line, warn_line, busy, f0, a_o, a_oe, w_o, w_oe;
    logic [3:0] supply_uv, overcurrent, boot_uv, pwm_in, pwm_run, hiz, hso, flip;
    logic [2:0] ph;
    int num_errors, tests_run;

    pfs_supervisor #(.CBC_LIMIT_CYC(LIM)) u_pfs_supervisor (
        .ref_clk(ref_clk), .rst(rst), .ctrl_reset_n(ctrl_reset_n),
        .supply_uv(supply_uv), .digital_core_rail_uv(core_uv),
        .temp_warn_above(above), .temp_warn_below_low(below),
        .thermal_shutdown(tsd), .oc_latch_strap(strap),
        .overcurrent(overcurrent), .bootstrap_cap_uv(boot_uv), .pwm_in(pwm_in),
        .bridge_hiz(hiz), .high_side_off(hso), .cbc_flip(flip),
        .shutdown_alarm_n_o(a_o), .shutdown_alarm_n_oe(a_oe),
        .thermal_warning_n_o(w_o), .thermal_warning_n_oe(w_oe));

    pfs_ctrl_model #(.GAP_CYC(40)) u_pfs_ctrl_model (
        .ref_clk(ref_clk), .rst(rst), .alarm_n_o(a_o), .alarm_n_oe(a_oe),
        .warn_n_o(w_o), .warn_n_oe(w_oe), .clear_req(clear_req),
        .ctrl_reset_n(ctrl_reset_n), .alarm_line(alarm_line),
        .warn_line(warn_line), .busy(busy));

    // ****************************************
    // clock and pwm sources
    // ****************************************
    initial begin
        ref_clk = 1'b0;
        forever #20 ref_clk = ~ref_clk;
    end
    // a stopped channel freezes at its last level
    always @(negedge ref_clk) begin
        ph <= ph + 3'h1;
        pwm_in <= (pwm_in & ~pwm_run) | ({4{ph[2]}} & pwm_run);
    end

    // ****************************************
    // helpers
    // ****************************************
    task automatic results();
        $display("comparisons %0d mismatches %0d", tests_run, num_errors);
        if (num_errors == 0 && tests_run > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask
    task automatic chk(input string nm, input logic [3:0] exp, input logic [3:0] got);
        tests_run++;
        if (got !== exp) begin
            num_errors++;
            $display("[FAIL] %s expected %h seen %h", nm, exp, got);
        end
    endtask
    task automatic outs(input logic [3:0] hz, input logic al, input logic wr);
        chk("bridge_hiz", hz, hiz);
        chk("alarm_line", {3'h0, al}, {3'h0, alarm_line});
        chk("warn_line", {3'h0, wr}, {3'h0, warn_line});
    endtask
    task automatic cyc(input int n);
        repeat (n) @(negedge ref_clk);
    endtask
    task automatic clear_toggle();
        int i;
        clear_req = 1'b1;
        cyc(1);
        clear_req = 1'b0;
        for (i = 0; i < 300 && busy; i++) cyc(1);
        if (busy) begin
            num_errors++;
            $display("[FAIL] reset release expected 1 seen 0");
            results();
        end
        cyc(3);
    endtask
    task automatic do_reset(input logic s);
        strap = s;
        rst = 1'b1;
        cyc(6);
        rst = 1'b0;
        cyc(3);
    endtask

    // ****************************************
    // scenarios
    // ****************************************
    task automatic t_supply();
        int i;
        for (i = 0; i < 5; i++) begin
            if (i < 4) supply_uv[i] = 1'b1;
            else core_uv = 1'b1;
            cyc(2);
            outs(4'hf, 1'b0, 1'b1);
            supply_uv = 4'h0;
            core_uv = 1'b0;
            cyc(3);
            outs(4'h0, 1'b1, 1'b1);
        end
        $display("test supply done");
    endtask
    task automatic t_warn();
        below = 1'b0;
        above = 1'b1;
        cyc(2);
        outs(4'h0, 1'b1, 1'b0);
        if (!warn_line) above = 1'b0; // controller backs off
        cyc(2);
        outs(4'h0, 1'b1, 1'b0);
        below = 1'b1;
        cyc(2);
        outs(4'h0, 1'b1, 1'b1);
        $display("test warning done");
    endtask
    task automatic t_thermal();
        above = 1'b1;
        below = 1'b0;
        tsd = 1'b1;
        cyc(2);
        outs(4'hf, 1'b0, 1'b0);
        tsd = 1'b0;
        cyc(3);
        outs(4'hf, 1'b0, 1'b0);
        clear_req = 1'b1;
        cyc(1);
        clear_req = 1'b0;
        cyc(60);
        outs(4'hf, 1'b1, 1'b0);
        above = 1'b0;
        below = 1'b1;
        clear_toggle();
        outs(4'h0, 1'b1, 1'b1);
        $display("test thermal done");
    endtask
    task automatic t_oc_latch();
        overcurrent = 4'h5;
        cyc(1);
        overcurrent = 4'h0;
        cyc(3);
        outs(4'h5, 1'b0, 1'b1);
        cyc(5);
        outs(4'h5, 1'b0, 1'b1);
        core_uv = 1'b1;
        cyc(2);
        core_uv = 1'b0;
        cyc(3);
        outs(4'h0, 1'b1, 1'b1);
        $display("test latched overcurrent done");
    endtask
    task automatic t_stuck();
        pwm_run = 4'hd;
        cyc(260);
        outs(4'h2, 1'b1, 1'b1);
        pwm_run = 4'hf;
        cyc(12);
        outs(4'h0, 1'b1, 1'b1);
        pwm_run = 4'h0;
        cyc(260);
        outs(4'hf, 1'b1, 1'b1);
        pwm_run = 4'hf;
        cyc(12);
        outs(4'h0, 1'b1, 1'b1);
        $display("test stuck pwm done");
    endtask
    task automatic t_boot();
        boot_uv = 4'hc;
        cyc(2);
        chk("high_side_off", 4'hc, hso);
        outs(4'h0, 1'b1, 1'b1);
        boot_uv = 4'h0;
        cyc(2);
        chk("high_side_off", 4'h0, hso);
        $display("test bootstrap done");
    endtask
    task automatic t_cbc();
        do_reset(1'b0);
        overcurrent = 4'h1;
        cyc(3);
        f0 = flip[0];
        outs(4'h0, 1'b1, 1'b1);
        cyc(8);
        chk("cbc_flip0", {3'h0, ~f0}, {3'h0, flip[0]});
        overcurrent = 4'h0;
        cyc(3);
        chk("cbc_flip", 4'h0, flip);
        overcurrent = 4'h1;
        cyc(LIM + 6);
        outs(4'h1, 1'b0, 1'b1);
        overcurrent = 4'h0;
        clear_toggle();
        outs(4'h0, 1'b1, 1'b1);
        $display("test current limit done");
    endtask

    initial begin
        rst = 1'b1;
        strap = 1'b1;
        supply_uv = 4'h0;
        core_uv = 1'b0;
        above = 1'b0;
        below = 1'b1;
        tsd = 1'b0;
        overcurrent = 4'h0;
        boot_uv = 4'h0;
        pwm_in = 4'h0;
        pwm_run = 4'hf;
        ph = 3'h0;
        clear_req = 1'b0;
        num_errors = 0;
        tests_run = 0;
        do_reset(1'b1);
        outs(4'h0, 1'b1, 1'b1);
        t_supply();
        t_warn();
        t_thermal();
        t_oc_latch();
        t_stuck();
        t_boot();
        t_cbc();
        results();
    end
endmodule // tb_pfs_supervisor
